// ---- verilog/cpu_status_control_alu.v ----
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "core_alu_map.vh"

// Behaviour
// - bits 15,14 show accumulator overflow state
// - bits 13,12 sticky saturation flags
// - bits 11,10 OR of pairs
// - clearing combined sticky clears both stickies
// - bit 9 loop running, bit 4 repeat
// - bit 8 nibble carry from bit 4/8
// - four-bit priority; user interrupts blocked when high
// - nesting off makes low priority read-only
// - bit 2 signed overflow, else cleared
// - zero only on affecting ops; negative flag
// - bit 0 carry; borrow on subtract
// - control 13:12 multiply sign mode
// - early stop ends loop, reads zero
// - control 7,6 enable accumulator saturation
// - control 4 selects saturation width
// - priority top clear-only, level above seven
// - stack frame flag bypasses page registers
// - rounding select and integer/fraction select
// - byte or word operands and results
// - 17x17 multiplier, all listed product modes
// - iterative divide, one cycle per bit
module cpu_status_control_alu (
   input  wire        sys_clk,
   input  wire        rst_n,
   // plain register port
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // alu request
   input  wire        alu_go,
   input  wire [2:0]  alu_op,
   input  wire        alu_byte,
   input  wire        alu_use_carry,
   input  wire        alu_sets_zero,
   input  wire [15:0] alu_a,
   input  wire [15:0] alu_b,
   output reg  [15:0] alu_result,
   // multiplier request
   input  wire        mul_go,
   input  wire [2:0]  mul_mode,
   input  wire [15:0] mul_a,
   input  wire [15:0] mul_b,
   output reg  [31:0] mul_product,
   // divider request
   input  wire        div_go,
   input  wire        div_signed,
   input  wire        div_long,
   input  wire [31:0] div_dividend,
   input  wire [15:0] div_divisor,
   output wire        div_busy,
   output reg         div_done,
   output reg  [15:0] div_quot,
   output reg  [15:0] div_rem,
   // accumulator engine events
   input  wire        acc_ovf_a,
   input  wire        acc_ovf_b,
   input  wire        acc_clip_a,
   input  wire        acc_clip_b,
   // loop sequencer events
   input  wire        loop_enter,
   input  wire        loop_exit,
   input  wire        loop_iter_end,
   input  wire        repeat_running,
   input  wire        frame_set,
   input  wire        frame_clr,
   input  wire        irq_priority_load,
   input  wire [2:0]  irq_priority_new,
   input  wire        nesting_off,
   output reg         loop_stop_req,
   // control outputs to the core
   output wire [3:0]  cpu_priority,
   output wire        user_irq_block,
   output wire        frame_base_only,
   output wire [1:0]  mul_sign_select,
   output wire        clip_en_a,
   output wire        clip_en_b,
   output wire        clip_en_write,
   output wire        clip_width_select,
   output wire        rounding_select,
   output wire        mul_int_frac_select
);

   reg [15:0] status_q;          // status register
   reg [15:0] control_q;         // control register storage
   reg [2:0]  depth_q;           // loop nesting depth
   reg        stop_pend_q;       // early stop waiting for iteration end
   reg        div_run_q;         // divider busy
   reg [4:0]  div_cnt_q;         // remaining steps
   reg [31:0] div_rem_q;         // partial remainder / dividend shift
   reg [15:0] div_dsr_q;         // divisor magnitude
   reg        div_qneg_q;        // quotient sign
   reg        div_rneg_q;        // remainder sign

   // combinational terms for the alu, multiplier and divider
   reg [16:0] sum_w;             // adder result with carry
   reg [15:0] res_w;
   reg        c_w;
   reg        dc_w;
   reg        ov_w;
   reg        n_w;
   reg        z_w;
   reg        arith_w;
   reg [4:0]  low_w;             // nibble adder
   reg [8:0]  mid_w;             // byte adder
   reg [16:0] mul_x_w;
   reg [16:0] mul_y_w;
   reg [33:0] mul_p_w;
   reg [16:0] div_trial_w;

   // negate a 16-bit word, used for divider sign fixes
   function [15:0] neg16;
      input [15:0] v;
      begin
         neg16 = (~v) + 16'h0001;
      end
   endfunction

   // any clearing of the combined sticky by a write of zero
   wire sticky_clear_w = reg_wr && (reg_addr == `ADDR_STATUS) && !reg_wdata[`ST_CLIP_ANY];
   wire status_wr_w = reg_wr && (reg_addr == `ADDR_STATUS);

   // alu datapath: byte or word, adds use carry/borrow in
   always @* begin
      arith_w = (alu_op == `OP_ADD) || (alu_op == `OP_SUB);
      sum_w   = 17'h00000;
      low_w   = 5'h00;
      mid_w   = 9'h000;
      if (alu_op == `OP_SUB) begin
         // a - b as a + ~b + 1, borrow is active low carry
         sum_w = {1'b0, alu_a} + {1'b0, ~alu_b} + {16'h0000, (alu_use_carry ? status_q[`ST_CARRY] : 1'b1)};
         low_w = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + {4'h0, (alu_use_carry ? status_q[`ST_CARRY] : 1'b1)};
         mid_w = {1'b0, alu_a[7:0]} + {1'b0, ~alu_b[7:0]} + {8'h00, (alu_use_carry ? status_q[`ST_CARRY] : 1'b1)};
      end else begin
         sum_w = {1'b0, alu_a} + {1'b0, alu_b} + {16'h0000, (alu_use_carry & status_q[`ST_CARRY])};
         low_w = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, (alu_use_carry & status_q[`ST_CARRY])};
         mid_w = {1'b0, alu_a[7:0]} + {1'b0, alu_b[7:0]} + {8'h00, (alu_use_carry & status_q[`ST_CARRY])};
      end
      case (alu_op)
         `OP_ADD, `OP_SUB : res_w = sum_w[15:0];
         `OP_AND          : res_w = alu_a & alu_b;
         `OP_OR           : res_w = alu_a | alu_b;
         `OP_XOR          : res_w = alu_a ^ alu_b;
         `OP_PASS         : res_w = alu_a;
         default          : res_w = alu_a;
      endcase
      if (alu_byte) begin
         // byte mode: flags from the low eight bits
         c_w  = mid_w[8];
         dc_w = low_w[4];
         n_w  = res_w[7];
         z_w  = (res_w[7:0] == 8'h00);
         ov_w = arith_w && ((alu_a[7] == (alu_op == `OP_SUB ? ~alu_b[7] : alu_b[7]))
                && (res_w[7] != alu_a[7]));
      end else begin
         c_w  = sum_w[16];
         dc_w = mid_w[8];
         n_w  = res_w[15];
         z_w  = (res_w == 16'h0000);
         ov_w = arith_w && ((alu_a[15] == (alu_op == `OP_SUB ? ~alu_b[15] : alu_b[15]))
                && (res_w[15] != alu_a[15]));
      end
   end

   // multiplier operands extended to 17 bits by mode
   // literal modes keep only the low five bits of the second operand
   // the 8x8 product zero-extends both bytes, so the signed multiply is safe
   always @* begin
      case (mul_mode)
         `MUL_SS    : begin mul_x_w = {mul_a[15], mul_a}; mul_y_w = {mul_b[15], mul_b}; end
         `MUL_UU    : begin mul_x_w = {1'b0, mul_a};      mul_y_w = {1'b0, mul_b};      end
         `MUL_SU    : begin mul_x_w = {mul_a[15], mul_a}; mul_y_w = {1'b0, mul_b};      end
         `MUL_US    : begin mul_x_w = {1'b0, mul_a};      mul_y_w = {mul_b[15], mul_b}; end
         `MUL_LIT_S : begin mul_x_w = {mul_a[15], mul_a}; mul_y_w = {12'h000, mul_b[4:0]}; end
         `MUL_LIT_U : begin mul_x_w = {1'b0, mul_a};      mul_y_w = {12'h000, mul_b[4:0]}; end
         `MUL_BYTE  : begin mul_x_w = {9'h000, mul_a[7:0]}; mul_y_w = {9'h000, mul_b[7:0]}; end
         default    : begin mul_x_w = {1'b0, mul_a};      mul_y_w = {1'b0, mul_b};      end
      endcase
      mul_p_w = $signed(mul_x_w) * $signed(mul_y_w);
   end

   // restoring divide trial subtraction
   always @* begin
      div_trial_w = {div_rem_q[31:15]} - {1'b0, div_dsr_q};
   end

   // status register: hardware events win over software clears
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= `STATUS_RESET;
      end else begin
         if (status_wr_w) begin
            // software may write flags; read-only bits are not touched here
            status_q[`ST_OVF_A]   <= reg_wdata[`ST_OVF_A];
            status_q[`ST_OVF_B]   <= reg_wdata[`ST_OVF_B];
            status_q[`ST_CLIP_A]  <= reg_wdata[`ST_CLIP_A] & ~sticky_clear_w;
            status_q[`ST_CLIP_B]  <= reg_wdata[`ST_CLIP_B] & ~sticky_clear_w;
            status_q[`ST_NIBBLE]  <= reg_wdata[`ST_NIBBLE];
            status_q[3:0]         <= reg_wdata[3:0];
            if (!nesting_off) begin
               status_q[`ST_PRIO_HI:`ST_PRIO_LO] <= reg_wdata[`ST_PRIO_HI:`ST_PRIO_LO];
            end
         end
         // overflow follows the accumulator engine's state
         if (acc_ovf_a || acc_ovf_b || !status_wr_w) begin
            if (!status_wr_w || acc_ovf_a) status_q[`ST_OVF_A] <= acc_ovf_a;
            if (!status_wr_w || acc_ovf_b) status_q[`ST_OVF_B] <= acc_ovf_b;
         end
         // saturation events set sticky bits, set wins over clear
         if (acc_clip_a) status_q[`ST_CLIP_A] <= 1'b1;
         if (acc_clip_b) status_q[`ST_CLIP_B] <= 1'b1;
         // the core's interrupt unit can always load the level
         if (irq_priority_load) status_q[`ST_PRIO_HI:`ST_PRIO_LO] <= irq_priority_new;
         // alu results update flags after the write so they win
         if (alu_go) begin
            status_q[`ST_NEG] <= n_w;
            status_q[`ST_OVF] <= ov_w;
            if (arith_w) begin
               status_q[`ST_CARRY]  <= c_w;
               status_q[`ST_NIBBLE] <= dc_w;
            end
            // zero only where the op affects it; with carry-in it only clears
            if (alu_sets_zero) begin
               if (!z_w) status_q[`ST_ZERO] <= 1'b0;
               else if (!alu_use_carry) status_q[`ST_ZERO] <= 1'b1;
            end
         end
      end
   end

   // control register, loop depth and early stop
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         control_q     <= `CONTROL_RESET;
         depth_q       <= 3'h0;
         stop_pend_q   <= 1'b0;
         loop_stop_req <= 1'b0;
      end else begin
         loop_stop_req <= 1'b0;
         if (reg_wr && (reg_addr == `ADDR_CONTROL)) begin
            // the early stop bit is never stored, it only arms the request
            control_q <= (control_q & ~`CONTROL_WMASK) | (reg_wdata & `CONTROL_WMASK);
            // top priority bit can only be cleared from software
            control_q[`CT_PRIO_TOP] <= control_q[`CT_PRIO_TOP] & reg_wdata[`CT_PRIO_TOP];
            if (reg_wdata[`CT_EARLY_STOP] && (depth_q != 3'h0)) begin
               stop_pend_q <= 1'b1;
            end
         end
         if (frame_set) control_q[`CT_FRAME] <= 1'b1;
         else if (frame_clr) control_q[`CT_FRAME] <= 1'b0;
         // finish the current iteration then end the loop
         if (stop_pend_q && loop_iter_end) begin
            stop_pend_q   <= 1'b0;
            loop_stop_req <= 1'b1;
         end
         // nesting depth counter saturates at seven
         // an entry and an exit in the same cycle cancel out
         if (loop_enter && !loop_exit && (depth_q != 3'h7)) depth_q <= depth_q + 3'h1;
         else if (loop_exit && !loop_enter && (depth_q != 3'h0)) depth_q <= depth_q - 3'h1;
      end
   end

   // registered alu and multiplier results
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alu_result  <= 16'h0000;
         mul_product <= 32'h00000000;
      end else begin
         if (alu_go) alu_result <= alu_byte ? {8'h00, res_w[7:0]} : res_w;
         if (mul_go) mul_product <= mul_p_w[31:0];
      end
   end

   // iterative divider: sixteen steps for both widths
   // a 32/16 quotient that does not fit sixteen bits is not flagged
   // div_go is ignored while a divide runs, so a late request is lost
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_run_q  <= 1'b0;
         div_cnt_q  <= 5'h00;
         div_rem_q  <= 32'h00000000;
         div_dsr_q  <= 16'h0000;
         div_qneg_q <= 1'b0;
         div_rneg_q <= 1'b0;
         div_done   <= 1'b0;
         div_quot   <= 16'h0000;
         div_rem    <= 16'h0000;
      end else begin
         div_done <= 1'b0;
         if (div_go && !div_run_q) begin
            div_run_q <= 1'b1;
            div_cnt_q <= `DIV_STEPS;
            if (div_long) begin
               div_rem_q  <= (div_signed && div_dividend[31]) ? (~div_dividend) + 32'h00000001
                                                               : div_dividend;
               div_rneg_q <= div_signed && div_dividend[31];
               div_qneg_q <= div_signed && (div_dividend[31] ^ div_divisor[15]);
            end else begin
               div_rem_q  <= {16'h0000, (div_signed && div_dividend[15]) ? neg16(div_dividend[15:0])
                                                                         : div_dividend[15:0]};
               div_rneg_q <= div_signed && div_dividend[15];
               div_qneg_q <= div_signed && (div_dividend[15] ^ div_divisor[15]);
            end
            div_dsr_q <= (div_signed && div_divisor[15]) ? neg16(div_divisor) : div_divisor;
         end else if (div_run_q) begin
            // one quotient bit per cycle, shifted in at the bottom
            if (!div_trial_w[16]) div_rem_q <= {div_trial_w[15:0], div_rem_q[14:0], 1'b1};
            else div_rem_q <= {div_rem_q[30:0], 1'b0};
            div_cnt_q <= div_cnt_q - 5'h01;
            if (div_cnt_q == 5'h01) begin
               div_run_q <= 1'b0;
               div_done  <= 1'b1;
               if (!div_trial_w[16]) begin
                  div_quot <= div_qneg_q ? neg16({div_rem_q[14:0], 1'b1}) : {div_rem_q[14:0], 1'b1};
                  div_rem  <= div_rneg_q ? neg16(div_trial_w[15:0]) : div_trial_w[15:0];
               end else begin
                  div_quot <= div_qneg_q ? neg16({div_rem_q[14:0], 1'b0}) : {div_rem_q[14:0], 1'b0};
                  div_rem  <= div_rneg_q ? neg16(div_rem_q[30:15]) : div_rem_q[30:15];
               end
            end
         end
      end
   end

   // read data one cycle after the read strobe
   // combined, loop and repeat bits are built here, so they never go stale
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADDR_STATUS : reg_rdata <= {status_q[15:12],
                                         status_q[`ST_OVF_A] | status_q[`ST_OVF_B],
                                         status_q[`ST_CLIP_A] | status_q[`ST_CLIP_B],
                                         (depth_q != 3'h0),
                                         status_q[8:5], repeat_running,
                                         status_q[3:0]};
            `ADDR_CONTROL: reg_rdata <= {control_q[15:12], 1'b0,
                                         depth_q, control_q[7:0]};
            `ADDR_NEST   : reg_rdata <= {13'h0000, depth_q};
            default      : reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // priority level and control decode to the core
   // these levels follow the registers directly, with no extra delay
   assign cpu_priority        = {control_q[`CT_PRIO_TOP], status_q[`ST_PRIO_HI:`ST_PRIO_LO]};
   assign user_irq_block      = control_q[`CT_PRIO_TOP]
                                | (status_q[`ST_PRIO_HI:`ST_PRIO_LO] == 3'h7);
   assign frame_base_only     = control_q[`CT_FRAME];
   assign mul_sign_select     = control_q[`CT_SIGN_HI:`CT_SIGN_LO];
   assign clip_en_a           = control_q[`CT_CLIP_A];
   assign clip_en_b           = control_q[`CT_CLIP_B];
   assign clip_en_write       = control_q[`CT_CLIP_DW];
   assign clip_width_select   = control_q[`CT_CLIP_WIDTH];
   assign rounding_select     = control_q[`CT_ROUND];
   assign mul_int_frac_select = control_q[`CT_INT_FRAC];
   assign div_busy            = div_run_q;

endmodule // cpu_status_control_alu
`default_nettype wire

// ---- verilog/core_alu_map.vh ----
`ifndef CORE_ALU_MAP_VH
`define CORE_ALU_MAP_VH
// register addresses on the plain register port
`define ADDR_STATUS      4'h0
`define ADDR_CONTROL     4'h1
`define ADDR_NEST        4'h2
// status register bit positions
`define ST_OVF_A         15
`define ST_OVF_B         14
`define ST_CLIP_A        13
`define ST_CLIP_B        12
`define ST_OVF_ANY       11
`define ST_CLIP_ANY      10
`define ST_LOOP          9
`define ST_NIBBLE        8
`define ST_PRIO_HI       7
`define ST_PRIO_LO       5
`define ST_REPEAT        4
`define ST_NEG           3
`define ST_OVF           2
`define ST_ZERO          1
`define ST_CARRY         0
// control register bit positions
`define CT_SIGN_HI       13
`define CT_SIGN_LO       12
`define CT_EARLY_STOP    11
`define CT_DEPTH_HI      10
`define CT_DEPTH_LO      8
`define CT_CLIP_A        7
`define CT_CLIP_B        6
`define CT_CLIP_DW       5
`define CT_CLIP_WIDTH    4
`define CT_PRIO_TOP      3
`define CT_FRAME         2
`define CT_ROUND         1
`define CT_INT_FRAC      0
// reset values
`define STATUS_RESET     16'h0000
`define CONTROL_RESET    16'h0020
// writable control bits (variable exception bit 15 kept as plain storage)
`define CONTROL_WMASK    16'hb0f3
// alu operation codes
`define OP_ADD           3'h0
`define OP_SUB           3'h1
`define OP_AND           3'h2
`define OP_OR            3'h3
`define OP_XOR           3'h4
`define OP_PASS          3'h5
// multiply mode codes
`define MUL_SS           3'h0
`define MUL_UU           3'h1
`define MUL_SU           3'h2
`define MUL_US           3'h3
`define MUL_LIT_S        3'h4
`define MUL_LIT_U        3'h5
`define MUL_BYTE         3'h6
// divider iterations, one per divisor bit
`define DIV_STEPS        5'h10
`endif

// ---- bench/core_alu_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "core_alu_map.vh"
// checker on the register, multiply and divide ports of the alu block
module core_alu_checker (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        mul_go,
   input wire logic [2:0]  mul_mode,
   input wire logic [15:0] mul_a,
   input wire logic [15:0] mul_b,
   input wire logic [31:0] mul_product,
   input wire logic        div_go,
   input wire logic        div_busy,
   input wire logic        div_done,
   input wire logic [3:0]  cpu_priority,
   input wire logic        user_irq_block,
   input wire logic [1:0]  mul_sign_select,
   input wire logic        rounding_select,
   input wire logic        mul_int_frac_select
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // combined flags agree with the per-accumulator flags in one read
   property p_or_flags;
      reg_rd && reg_addr == `ADDR_STATUS |=> reg_rdata[11] == (reg_rdata[15] | reg_rdata[14])
         && reg_rdata[10] == (reg_rdata[13] | reg_rdata[12]);
   endproperty
   a_or_flags: assert property (p_or_flags) else $error("combined flag wrong");
   property p_stop_zero;
      reg_rd && reg_addr == `ADDR_CONTROL |=> !reg_rdata[11];
   endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("early stop read as one");
   property p_irq_block;
      user_irq_block == (cpu_priority[3] || cpu_priority[2:0] == 3'h7);
   endproperty
   a_irq_block: assert property (p_irq_block) else $error("irq block wrong");
   property p_top_clear;
      !$rose(cpu_priority[3]);
   endproperty
   a_top_clear: assert property (p_top_clear) else $error("priority top set");
   // one cycle per divisor bit, so the answer lands a fixed time later
   property p_div_time;
      div_go && !div_busy |=> div_busy [*8] ##9 div_done;
   endproperty
   a_div_time: assert property (p_div_time) else $error("divide timing wrong");
   property p_mul_uu;
      mul_go && mul_mode == `MUL_UU |=> mul_product == {16'h0, $past(mul_a)} * {16'h0, $past(mul_b)};
   endproperty
   a_mul_uu: assert property (p_mul_uu) else $error("unsigned product wrong");
   property p_sign_wr;
      reg_wr && reg_addr == `ADDR_CONTROL |=> mul_sign_select == $past(reg_wdata[13:12]);
   endproperty
   a_sign_wr: assert property (p_sign_wr) else $error("sign mode wrong");
   property p_round_wr;
      reg_wr && reg_addr == `ADDR_CONTROL |=> {rounding_select, mul_int_frac_select} == $past(reg_wdata[1:0]);
   endproperty
   a_round_wr: assert property (p_round_wr) else $error("round mode wrong");
   c_div: cover property (div_done);
   c_block: cover property ($rose(user_irq_block));
   c_byte: cover property (mul_go && mul_mode == `MUL_BYTE);
endmodule // core_alu_checker
`default_nettype wire

// ---- bench/core_event_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// accumulator engine and loop sequencer stand-in: one-cycle event pulses
module core_event_model (
   input wire logic  sys_clk,
   input wire logic  rst_n,
   input wire logic  ev_go,
   input wire logic [2:0] ev_code,
   input wire logic  loop_stop_req,
   output logic      loop_enter,
   output logic      loop_exit,
   output logic      loop_iter_end,
   output logic      acc_clip_a,
   output logic      acc_clip_b,
   output logic      frame_set,
   output logic      frame_clr,
   output logic      irq_priority_load
);
   // iterations end every other cycle; the block raises its stop request at
   // an iteration end and the sequencer leaves the loop on the next cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {loop_enter, loop_exit, loop_iter_end} <= 3'h0;
         {acc_clip_a, acc_clip_b, frame_set, frame_clr, irq_priority_load} <= 5'h0;
      end else begin
         loop_enter <= ev_go && ev_code == 3'h0;
         loop_exit <= (ev_go && ev_code == 3'h1) || loop_stop_req;
         loop_iter_end <= !loop_iter_end;
         acc_clip_a <= ev_go && ev_code == 3'h2;
         acc_clip_b <= ev_go && ev_code == 3'h3;
         frame_set <= ev_go && ev_code == 3'h4;
         frame_clr <= ev_go && ev_code == 3'h5;
         irq_priority_load <= ev_go && ev_code == 3'h6;
      end
   end
endmodule // core_event_model
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "core_alu_map.vh"
module tb;
   logic sys_clk, rst_n, reg_wr = 0, reg_rd = 0, alu_go = 0, alu_byte = 0, mul_go = 0;
   logic alu_use_carry = 0, alu_sets_zero = 0, div_go = 0, div_signed = 0, div_long = 0;
   logic acc_ovf_a = 0, acc_ovf_b = 0, repeat_running = 0, nesting_off = 0, ev_go = 0;
   logic [3:0] reg_addr = 0, cpu_priority;
   logic [2:0] alu_op = 0, mul_mode = 0, irq_priority_new = 0, ev_code = 0;
   logic [15:0] reg_wdata = 0, alu_a = 0, alu_b = 0, mul_a = 0, mul_b = 0, div_divisor = 0;
   logic [31:0] div_dividend = 0, mul_product, err_total = 0, n_tests = 0, cyc = 0;
   logic [15:0] reg_rdata, alu_result, div_quot, div_rem;
   logic div_busy, div_done, loop_stop_req, user_irq_block, frame_base_only, clip_en_a;
   logic clip_en_b, clip_en_write, clip_width_select, rounding_select, mul_int_frac_select;
   logic loop_enter, loop_exit, loop_iter_end, acc_clip_a, acc_clip_b, frame_set, frame_clr;
   logic irq_priority_load;
   logic [1:0] mul_sign_select;
   cpu_status_control_alu u_dut (.*);
   core_event_model u_ev (.*);
   initial begin
      sys_clk = 0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata & m, e);
   endtask
   task automatic ev(input logic [2:0] c);
      @(posedge sys_clk) {ev_go, ev_code} <= {1'b1, c};
      @(posedge sys_clk) ev_go <= 1'b0;
   endtask
   task automatic alu(input logic [4:0] o, input logic [15:0] a, b, e);
      @(posedge sys_clk) {alu_go, alu_op, alu_byte, alu_sets_zero, alu_a, alu_b} <= {1'b1, o, a, b};
      @(posedge sys_clk) alu_go <= 1'b0;
      #1 chk(alu_result, e);
   endtask
   task automatic mul(input logic [2:0] m, input logic [15:0] a, b, input logic [31:0] e);
      @(posedge sys_clk) {mul_go, mul_mode, mul_a, mul_b} <= {1'b1, m, a, b};
      @(posedge sys_clk) mul_go <= 1'b0;
      #1 chk(mul_product, e);
   endtask
   task automatic div(input logic s, l, input logic [31:0] n, input logic [15:0] v, q, r);
      int i;
      @(posedge sys_clk) {div_go, div_signed, div_long, div_dividend, div_divisor} <= {1'b1, s, l, n, v};
      @(posedge sys_clk) div_go <= 1'b0;
      for (i = 0; i < 20 && div_done !== 1'b1; i++) @(posedge sys_clk) #1;
      chk({div_quot, div_rem}, {q, r});
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests != 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // cut a hang short well above the hundred and fifty or so cycles the run needs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         final_report;
      end
   end
   initial begin
      rst_n = 0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(`ADDR_STATUS, 16'hffff, `STATUS_RESET);
      rchk(`ADDR_CONTROL, 16'hffff, `CONTROL_RESET);
      rchk(4'h7, 16'hffff, 16'h0000);
      wr(`ADDR_CONTROL, 16'hffff);
      rchk(`ADDR_CONTROL, 16'hffff, `CONTROL_WMASK);
      chk({clip_en_a, clip_en_b, clip_en_write, clip_width_select, rounding_select,
           mul_int_frac_select}, 6'h3f);
      for (int m = 0; m < 3; m++) begin
         wr(`ADDR_CONTROL, {2'h0, m[1:0], 12'h020});
         #1 chk(mul_sign_select, m[1:0]);
      end
      // op, byte, sets zero; flags after the first five in nibble carry and low status bits
      alu({`OP_ADD, 2'h3}, 16'h001f, 16'h0001, 16'h0020);
      rchk(`ADDR_STATUS, 16'h010f, 16'h0100);
      alu({`OP_ADD, 2'h1}, 16'hffff, 16'h0001, 16'h0000);
      rchk(`ADDR_STATUS, 16'h010f, 16'h0103);
      alu({`OP_AND, 2'h0}, 16'hffff, 16'h0000, 16'h0000);
      rchk(`ADDR_STATUS, 16'h010f, 16'h0103);
      alu({`OP_OR, 2'h1}, 16'h0001, 16'h0000, 16'h0001);
      rchk(`ADDR_STATUS, 16'h010f, 16'h0101);
      alu({`OP_ADD, 2'h1}, 16'h7fff, 16'h0001, 16'h8000);
      rchk(`ADDR_STATUS, 16'h010f, 16'h010c);
      alu({`OP_SUB, 2'h1}, 16'h0000, 16'h0001, 16'hffff);
      alu_use_carry <= 1'b1;
      alu({`OP_SUB, 2'h1}, 16'h0005, 16'h0001, 16'h0003);
      alu_use_carry <= 1'b0;
      @(posedge sys_clk) acc_ovf_a <= 1'b1;
      ev(3'h3);
      rchk(`ADDR_STATUS, 16'hfc00, 16'h9c00);
      @(posedge sys_clk) acc_ovf_a <= 1'b0;
      rchk(`ADDR_STATUS, 16'hfc00, 16'h1400);
      wr(`ADDR_STATUS, 16'h0000);
      rchk(`ADDR_STATUS, 16'hfc00, 16'h0000);
      ev(3'h0);
      ev(3'h0);
      repeat_running <= 1'b1;
      rchk(`ADDR_CONTROL, 16'h0f00, 16'h0200);
      rchk(`ADDR_STATUS, 16'h0210, 16'h0210);
      wr(`ADDR_CONTROL, 16'h0820);
      repeat (3) @(posedge sys_clk);
      rchk(`ADDR_CONTROL, 16'h0f00, 16'h0100);
      ev(3'h1);
      repeat_running <= 1'b0;
      rchk(`ADDR_STATUS, 16'h0210, 16'h0000);
      irq_priority_new <= 3'h7;
      ev(3'h6);
      @(posedge sys_clk) #1 chk({user_irq_block, cpu_priority}, 5'h17);
      wr(`ADDR_STATUS, 16'h0060);
      #1 chk({user_irq_block, cpu_priority}, 5'h03);
      nesting_off <= 1'b1;
      wr(`ADDR_STATUS, 16'h00a0);
      #1 chk(cpu_priority, 4'h3);
      ev(3'h4);
      @(posedge sys_clk) #1 chk(frame_base_only, 1'b1);
      mul(`MUL_SS, 16'hfffe, 16'h0003, 32'hfffffffa);
      mul(`MUL_UU, 16'hffff, 16'hffff, 32'hfffe0001);
      mul(`MUL_SU, 16'hffff, 16'h0002, 32'hfffffffe);
      mul(`MUL_US, 16'h0002, 16'hffff, 32'hfffffffe);
      mul(`MUL_LIT_S, 16'hffff, 16'h0003, 32'hfffffffd);
      mul(`MUL_LIT_U, 16'h0010, 16'h001f, 32'h000001f0);
      mul(`MUL_BYTE, 16'h12ff, 16'h34ff, 32'h0000fe01);
      div(1'b0, 1'b1, 32'h000186a0, 16'h0007, 16'h37cd, 16'h0005);
      div(1'b1, 1'b0, 32'h0000fff9, 16'h0002, 16'hfffd, 16'hffff);
      final_report;
   end
endmodule // tb
bind cpu_status_control_alu core_alu_checker u_chk (.*);
`default_nettype wire
